// ### rtl/mode_reg_pkg.sv
package mode_reg_pkg;
  localparam int ADDR_W = 22;
  localparam int NUM_REGS = 7;
  localparam int SEL_HI = 20;
  localparam int SEL_LO = 18;
  localparam int RSV_TOP = 21;
  localparam int RSV_ROW = 17;
  localparam logic [2:0] SEL_UNUSED = 3'h7;
  localparam logic [3:0] WR_LAST_CODE = 4'h9;
  localparam logic [21:0] REG_RESET = 22'h000000;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SET_CYCLE_NS = 8;
  localparam int UPDATE_DELAY_NS = 120;
  localparam int SET_CYCLE_CLKS = (SET_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int UPDATE_CLKS = (UPDATE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  typedef enum logic [1:0] {
    CMD_OTHER,
    CMD_SET,
    CMD_DESELECT
  } cmd_kind_t;

  function automatic logic [2:0] reg_select(input logic [ADDR_W-1:0] a);
    reg_select = a[SEL_HI:SEL_LO];
  endfunction
endpackage

// ### rtl/mode_write_if.sv
interface mode_write_if;
  import mode_reg_pkg::*;
  logic wrEn;
  logic [2:0] wrSel;
  logic [ADDR_W-1:0] wrData;
  logic [3:0] wrRecCode;
  logic wrRecReserved;
  logic [4:0] wrRecClks;
  logic [3:0] rdPreClks;
  modport ctrl (output wrEn, output wrSel, output wrData,
    input wrRecCode, input wrRecReserved, input wrRecClks, input rdPreClks);
  modport decode (input wrEn, input wrSel, input wrData,
    output wrRecCode, output wrRecReserved, output wrRecClks, output rdPreClks);
endinterface

// ### rtl/wr_recovery_decode.sv
module wr_recovery_decode
  import mode_reg_pkg::*;
(
  // Decoder side
  mode_write_if.decode mw
);
  wire [3:0] code;
  wire reservedCode;
  logic [4:0] recClks;

  assign code = {mw.wrData[13], mw.wrData[11:9]};
  assign reservedCode = code > WR_LAST_CODE;

  // Codes 0110 and 0111 are swapped in the table, so a plain linear formula does not fit.
  always_comb begin
    unique case (code)
      4'h0: recClks = 5'hA;
      4'h1: recClks = 5'hC;
      4'h2: recClks = 5'hE;
      4'h3: recClks = 5'h10;
      4'h4: recClks = 5'h12;
      4'h5: recClks = 5'h14;
      4'h6: recClks = 5'h18;
      4'h7: recClks = 5'h16;
      4'h8: recClks = 5'h1A;
      4'h9: recClks = 5'h1C;
      // Unsupported codes give zero clocks, so a stray setting cannot stretch any timing.
      default: recClks = 5'h00;
    endcase
  end

  assign mw.wrRecCode = code;
  assign mw.wrRecReserved = reservedCode;
  assign mw.wrRecClks = recClks;
  assign mw.rdPreClks = recClks[4:1];
endmodule

// ### rtl/dram_mode_register_programming.sv
module dram_mode_register_programming
  import mode_reg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Command pins, sampled on clk
  input wire logic chipSelectN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeEnableN,
  input wire logic [1:0] groupSelect,
  input wire logic [1:0] bankSelect,
  input wire logic topRowPin,
  input wire logic [13:0] rowAddr,
  input wire logic termControlInput,
  input wire logic allBanksIdle,
  // Register contents
  output logic [ADDR_W-1:0] modeReg [NUM_REGS],
  output logic [NUM_REGS-1:0] regWritten,
  // Decoded first register fields
  output logic [4:0] writeRecoveryClks,
  output logic [3:0] readToPrechargeClks,
  output logic recoveryCodeReserved,
  output logic reservedBitsSet,
  // Timing status
  output logic setCycleBusy,
  output logic updateBusy,
  output logic protocolViolation
);
  mode_write_if mw();

  wire isSet;
  wire isDeselect;
  wire isOther;
  wire [ADDR_W-1:0] capturedAddr;
  wire [2:0] sel;
  wire selValid;
  wire earlySet;
  wire earlyOther;
  wire termHighTooSoon;
  wire notIdle;
  wire termEnabled;

  logic [ADDR_W-1:0] modeReg_ff [NUM_REGS];
  logic [NUM_REGS-1:0] regWritten_ff;
  logic [CNT_W-1:0] setCnt_ff;
  logic [CNT_W-1:0] nxt_setCnt;
  logic [CNT_W-1:0] updCnt_ff;
  logic [CNT_W-1:0] nxt_updCnt;
  logic [4:0] wrRec_ff;
  logic [3:0] rdPre_ff;
  logic recRsv_ff;
  logic rsvBits_ff;
  logic violation_ff;
  cmd_kind_t cmdKind;

  // Commands are decoded from the strobes; the array path is not part of this block.
  assign isSet = !chipSelectN && !rowStrobeN && !colStrobeN && !writeEnableN;
  assign isDeselect = chipSelectN;
  assign isOther = cmdKind == CMD_OTHER;
  assign cmdKind = isSet ? CMD_SET : (isDeselect ? CMD_DESELECT : CMD_OTHER);

  // Pins 16:14 do not exist on this bus and read as zero.
  assign capturedAddr = {groupSelect, bankSelect, topRowPin, 3'h0, rowAddr};
  assign sel = reg_select(capturedAddr);
  assign selValid = sel != SEL_UNUSED;

  assign mw.wrEn = ce && isSet && selValid;
  assign mw.wrSel = sel;
  assign mw.wrData = capturedAddr;

  wr_recovery_decode u_dec (
    .mw(mw)
  );

  // Nominal termination enable lives in register one, bits 10:8.
  assign termEnabled = regWritten_ff[1] && (modeReg_ff[1][10:8] != 3'h0);
  assign earlySet = isSet && (setCnt_ff != CNT_ZERO);
  assign earlyOther = isOther && (updCnt_ff != CNT_ZERO);
  assign termHighTooSoon = termEnabled && termControlInput && (isSet || updCnt_ff != CNT_ZERO);
  assign notIdle = isSet && !allBanksIdle;

  // A write restarts both counters; the shorter set cycle is the floor for the next write.
  assign nxt_setCnt = isSet ? CNT_W'(SET_CYCLE_CLKS) : (setCnt_ff != CNT_ZERO ? setCnt_ff - CNT_ONE : CNT_ZERO);
  assign nxt_updCnt = isSet ? CNT_W'(UPDATE_CLKS) : (updCnt_ff != CNT_ZERO ? updCnt_ff - CNT_ONE : CNT_ZERO);

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        modeReg_ff[i] <= REG_RESET;
      end
      regWritten_ff <= '0;
    end else if (mw.wrEn) begin
      modeReg_ff[mw.wrSel] <= mw.wrData;
      regWritten_ff[mw.wrSel] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      setCnt_ff <= CNT_ZERO;
      updCnt_ff <= CNT_ZERO;
      violation_ff <= 1'b0;
    end else if (ce) begin
      setCnt_ff <= nxt_setCnt;
      updCnt_ff <= nxt_updCnt;
      violation_ff <= earlySet || earlyOther || termHighTooSoon || notIdle || (isSet && !selValid);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wrRec_ff <= 5'h00;
      rdPre_ff <= 4'h0;
      recRsv_ff <= 1'b0;
      rsvBits_ff <= 1'b0;
    end else if (mw.wrEn && mw.wrSel == 3'h0) begin
      wrRec_ff <= mw.wrRecClks;
      rdPre_ff <= mw.rdPreClks;
      recRsv_ff <= mw.wrRecReserved;
      rsvBits_ff <= capturedAddr[RSV_TOP] || capturedAddr[RSV_ROW];
    end
  end

  assign modeReg = modeReg_ff;
  assign regWritten = regWritten_ff;
  assign writeRecoveryClks = wrRec_ff;
  assign readToPrechargeClks = rdPre_ff;
  assign recoveryCodeReserved = recRsv_ff;
  assign reservedBitsSet = rsvBits_ff;
  assign setCycleBusy = setCnt_ff != CNT_ZERO;
  assign updateBusy = updCnt_ff != CNT_ZERO;
  assign protocolViolation = violation_ff;

  // Assertions. They watch only what this block drives; the controller side is checked by the bench.
  reg_write_a: assert property (@(posedge clk) disable iff (srst)
    mw.wrEn |=> modeReg_ff[$past(sel)] == $past(capturedAddr))
    else $error("register not written");
  ce_hold_a: assert property (@(posedge clk) disable iff (srst)
    !ce |=> $stable(regWritten_ff) && $stable(setCnt_ff) && $stable(updCnt_ff))
    else $error("state moved with enable low");
  sel_route_a: assert property (@(posedge clk) disable iff (srst)
    (ce && isSet && sel == SEL_UNUSED) |=> $stable(regWritten_ff))
    else $error("unused code wrote");
  sel_flag_a: assert property (@(posedge clk) disable iff (srst)
    (ce && isSet && !selValid) |=> protocolViolation)
    else $error("unused code not flagged");
  set_spacing_a: assert property (@(posedge clk) disable iff (srst)
    (ce && isSet) |=> updateBusy [*2])
    else $error("update delay not held");
  set_busy_a: assert property (@(posedge clk) disable iff (srst)
    (ce && isSet) |=> setCycleBusy)
    else $error("set cycle not started");
  set_cycle_a: assert property (@(posedge clk) disable iff (srst)
    (ce && earlySet) |=> protocolViolation)
    else $error("early write not flagged");
  other_early_a: assert property (@(posedge clk) disable iff (srst)
    (ce && earlyOther) |=> protocolViolation)
    else $error("early command not flagged");
  update_end_a: assert property (@(posedge clk) disable iff (srst)
    (ce && !isSet && updCnt_ff == CNT_ONE) |=> !updateBusy)
    else $error("update delay overran");
  idle_flag_a: assert property (@(posedge clk) disable iff (srst)
    (ce && notIdle) |=> protocolViolation)
    else $error("busy write not flagged");
  pin_map_a: assert property (@(posedge clk) disable iff (srst)
    mw.wrEn |-> mw.wrData[21:17] == {groupSelect, bankSelect, topRowPin} && mw.wrData[13:0] == rowAddr)
    else $error("pin map");
  rec_decode_a: assert property (@(posedge clk) disable iff (srst)
    (mw.wrEn && sel == 3'h0 && !mw.wrRecReserved) |=> writeRecoveryClks == {readToPrechargeClks, 1'b0})
    else $error("recovery pair");
  rec_swap_a: assert property (@(posedge clk) disable iff (srst)
    (mw.wrEn && sel == 3'h0 && mw.wrRecCode == 4'h6) |=> writeRecoveryClks == 5'h18 && readToPrechargeClks == 4'hC)
    else $error("swapped recovery entry");
  rec_rsv_a: assert property (@(posedge clk) disable iff (srst)
    mw.wrRecReserved |-> mw.wrRecCode > 4'h9)
    else $error("reserved code");
  rsv_zero_a: assert property (@(posedge clk) disable iff (srst)
    (mw.wrEn && sel == 3'h0 && mw.wrRecReserved) |=> recoveryCodeReserved && writeRecoveryClks == 5'h00)
    else $error("reserved code decoded");
  rsv_bits_a: assert property (@(posedge clk) disable iff (srst)
    (mw.wrEn && sel == 3'h0 && capturedAddr[21]) |=> reservedBitsSet)
    else $error("reserved bit");
  rsv_clear_a: assert property (@(posedge clk) disable iff (srst)
    (mw.wrEn && sel == 3'h0 && !capturedAddr[21] && !capturedAddr[17]) |=> !reservedBitsSet)
    else $error("reserved flag stuck");
  term_early_a: assert property (@(posedge clk) disable iff (srst)
    (ce && termHighTooSoon) |=> protocolViolation)
    else $error("termination early");
  term_free_a: assert property (@(posedge clk) disable iff (srst)
    (ce && !termEnabled && !earlySet && !earlyOther && !notIdle && !(isSet && !selValid)) |=> !protocolViolation)
    else $error("termination level flagged");

  // Covers for the main scenarios.
  write_c: cover property (@(posedge clk) mw.wrEn && sel == 3'h0);
  six_c: cover property (@(posedge clk) mw.wrEn && sel == 3'h6);
  viol_c: cover property (@(posedge clk) protocolViolation);
  term_c: cover property (@(posedge clk) ce && termHighTooSoon);
  frozen_c: cover property (@(posedge clk) !ce && isSet);
endmodule

// ### verif/ctrl_model.sv
module ctrl_model
  import mode_reg_pkg::*;
(
  // Clock
  input wire logic clk,
  // Command pins
  output logic chipSelectN,
  output logic rowStrobeN,
  output logic colStrobeN,
  output logic writeEnableN,
  output logic [1:0] groupSelect,
  output logic [1:0] bankSelect,
  output logic topRowPin,
  output logic [13:0] rowAddr,
  // Status
  output logic modelError
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = 4'hF;
    {groupSelect, bankSelect, topRowPin, rowAddr} = 19'h00000;
    modelError = 1'b0;
  end
  task automatic issue(input cmd_kind_t k, input logic [ADDR_W-1:0] a, input bit bad, input int n);
    logic rsv;
    rsv = a[20:18] == SEL_UNUSED || (a[20:18] == 3'h0 && (a[21] || a[17] || {a[13], a[11:9]} > WR_LAST_CODE));
    if (k == CMD_SET && rsv && !bad) begin
      modelError = 1'b1;
    end else begin
      @(negedge clk);
      chipSelectN = k == CMD_DESELECT;
      rowStrobeN = 1'b0;
      {colStrobeN, writeEnableN} = {2{k != CMD_SET}};
      {groupSelect, bankSelect, topRowPin, rowAddr} = {a[21:17], a[13:0]};
      repeat (n) @(negedge clk);
      {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = 4'hF;
      // Released lines carry the inverse, so a stale value cannot pass for a held one.
      {groupSelect, bankSelect, topRowPin, rowAddr} = ~{a[21:17], a[13:0]};
    end
  endtask
endmodule

// ### verif/tb.sv
module tb import mode_reg_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, ce, termControlInput, allBanksIdle, modelError, topRowPin;
  logic chipSelectN, rowStrobeN, colStrobeN, writeEnableN;
  logic [1:0] groupSelect, bankSelect;
  logic [13:0] rowAddr;
  logic [ADDR_W-1:0] modeReg [NUM_REGS];
  logic [NUM_REGS-1:0] regWritten;
  logic [4:0] writeRecoveryClks;
  logic [3:0] readToPrechargeClks;
  logic recoveryCodeReserved, reservedBitsSet, setCycleBusy, updateBusy, protocolViolation;
  logic [ADDR_W-1:0] a;
  int failCount = 0;
  int compares = 0;
  int wrTab [10] = '{10, 12, 14, 16, 18, 20, 24, 22, 26, 28};
  dram_mode_register_programming dut_u (.clk, .srst, .ce, .chipSelectN, .rowStrobeN, .colStrobeN,
    .writeEnableN, .groupSelect, .bankSelect, .topRowPin, .rowAddr, .termControlInput, .allBanksIdle,
    .modeReg, .regWritten, .writeRecoveryClks, .readToPrechargeClks, .recoveryCodeReserved,
    .reservedBitsSet, .setCycleBusy, .updateBusy, .protocolViolation);
  ctrl_model ctl_u (.clk, .chipSelectN, .rowStrobeN, .colStrobeN, .writeEnableN, .groupSelect,
    .bankSelect, .topRowPin, .rowAddr, .modelError);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chkB(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chkW(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic printVerdict;
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic register_set_command(input logic [ADDR_W-1:0] v, input bit bad = 1'b0, input int n = 1);
    ctl_u.issue(CMD_SET, v, bad, n);
  endtask
  initial begin
    {srst, ce, termControlInput, allBanksIdle} = 4'hD;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    for (int s = 0; s < NUM_REGS; s++) chkW(modeReg[s], REG_RESET);
    chkW(22'(regWritten), 22'h000000);
    for (int c = 0; c < 16; c++) begin
      a = 22'h000000;
      {a[13], a[11:9], a[8:0]} = {4'(c), 9'(c * 37)};
      register_set_command(a, c > 9);
      chkW(modeReg[0], a);
      chkW(22'(writeRecoveryClks), c > 9 ? 22'h000000 : 22'(wrTab[c]));
      chkW(22'(readToPrechargeClks), c > 9 ? 22'h000000 : 22'(wrTab[c] / 2));
      chkB(recoveryCodeReserved, c > 9);
      chkB(setCycleBusy & updateBusy & !protocolViolation, 1'b1);
    end
    for (int s = 1; s < NUM_REGS; s++) begin
      a = {1'b0, 3'(s), 4'hF, 14'(16'h2A5C ^ s)};
      register_set_command(a);
      chkW(modeReg[s], a & 22'h3E3FFF);
    end
    chkW(22'(regWritten), 22'h00007F);
    $display("test field decode done");
    for (int i = 0; i < 3; i++) begin
      a = i == 0 ? 22'h200000 : (i == 1 ? 22'h020000 : 22'h000000);
      register_set_command(a, 1'b1);
      chkB(reservedBitsSet, i < 2);
      chkW(modeReg[0], a);
    end
    register_set_command(22'h1C1234, 1'b1);
    chkB(protocolViolation, 1'b1);
    chkW(modeReg[0], 22'h000000);
    register_set_command(22'h040001, 1'b0, 2);
    chkB(protocolViolation, 1'b1);
    chkW(modeReg[1], 22'h040001);
    $display("test refusals done");
    for (int g = 13; g < 15; g++) begin
      register_set_command(22'h040000);
      repeat (g) @(negedge clk);
      ctl_u.issue(CMD_OTHER, 22'h000000, 1'b0, 1);
      chkB(protocolViolation, g == 13);
    end
    termControlInput = 1'b1;
    register_set_command(22'h040000);
    repeat (2) @(negedge clk);
    chkB(protocolViolation, 1'b0);
    termControlInput = 1'b0;
    register_set_command(22'h040100);
    termControlInput = 1'b1;
    @(negedge clk);
    chkB(protocolViolation, 1'b1);
    termControlInput = 1'b0;
    repeat (16) @(negedge clk);
    termControlInput = 1'b1;
    repeat (2) @(negedge clk);
    chkB(protocolViolation, 1'b0);
    $display("test timing done");
    {termControlInput, allBanksIdle} = 2'h0;
    register_set_command(22'h080055);
    chkB(protocolViolation, 1'b1);
    chkW(modeReg[2], 22'h080055);
    {allBanksIdle, ce} = 2'h2;
    register_set_command(22'h0C0AAA);
    ce = 1'b1;
    chkW(modeReg[3], {1'b0, 3'h3, 4'h8, 14'h2A5F});
    chkB(modelError, 1'b0);
    ctl_u.issue(CMD_SET, 22'h1C0000, 1'b0, 1);
    chkB(modelError, 1'b1);
    chkW(22'(regWritten), 22'h00007F);
    $display("test idle and enable done");
    printVerdict;
  end
  initial begin
    // About 125 cycles are needed; the margin only catches a hang.
    #20000;
    failCount++;
    $display("ERROR %0t watchdog expired", $time);
    printVerdict;
  end
endmodule
